// ==== rtl/ipc_pkg.sv ====
// shared constants and carrier types for the image presence checker
package ipc_pkg;
    localparam int unsigned ADDR_W        = 24;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned CHECK_BYTES   = 16;
    localparam int unsigned CNT_W         = 5;
    localparam logic [7:0]  BLANK_BYTE    = 8'hFF;
    localparam logic [23:0] START_ADDR_RST = 24'h000000;

    // request group towards the flash-access block
    typedef struct packed {
        logic [23:0] addr;
        logic        read;
        logic        rden;
    } ipc_flash_req_t;

    // answer group from the flash-access block
    typedef struct packed {
        logic       busy;
        logic       valid;
        logic [7:0] data;
    } ipc_flash_rsp_t;

    typedef enum logic [2:0] {
        IPC_IDLE,
        IPC_SETUP,
        IPC_LAUNCH,
        IPC_WAIT,
        IPC_DRAIN,
        IPC_DONE
    } ipc_state_t;
endpackage : ipc_pkg

// ==== rtl/ipc_byte_judge.sv ====
// byte judge: folds read bytes into blank and partial verdicts
`timescale 1ns/1ps
`default_nettype none
module ipc_byte_judge
    import ipc_pkg::*;
(
    input  wire logic             ref_clk_i,
    input  wire logic             srst_i,
    input  wire logic             clear_i,
    input  wire logic             take_i,
    input  wire logic [7:0]       byte_i,
    output logic                  any_blank_o,
    output logic                  all_blank_o
);
    logic any_blank_q;
    logic any_blank_d;
    logic all_blank_q;
    logic all_blank_d;

    // blank byte test
    function automatic logic is_blank(input logic [7:0] b);
        return b == BLANK_BYTE;
    endfunction : is_blank

    // next verdict: any blank byte marks a partial or empty image
    always_comb begin
        any_blank_d = any_blank_q;
        all_blank_d = all_blank_q;
        if (clear_i) begin
            any_blank_d = 1'b0;
            all_blank_d = 1'b1;
        end else if (take_i) begin
            any_blank_d = any_blank_q | is_blank(byte_i);
            all_blank_d = all_blank_q & is_blank(byte_i);
        end
    end

    // verdict registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            any_blank_q <= 1'b0;
            all_blank_q <= 1'b1;
        end else begin
            any_blank_q <= any_blank_d;
            all_blank_q <= all_blank_d;
        end
    end

    assign any_blank_o = any_blank_q;
    assign all_blank_o = all_blank_q;
endmodule : ipc_byte_judge
`default_nettype wire

// ==== rtl/ipc_checker.sv ====
// image presence checker: reads the image head and flags an invalid image
`timescale 1ns/1ps
`default_nettype none
module ipc_checker
    import ipc_pkg::*;
(
    input  wire logic             ref_clk_i,
    input  wire logic             srst_i,
    input  wire logic             start_i,
    input  wire logic [23:0]      start_addr_i,
    input  wire ipc_flash_rsp_t   flash_rsp_i,
    output ipc_flash_req_t        flash_req_o,
    output logic                  busy_o,
    output logic                  done_o,
    output logic                  invalid_o
);
    ipc_state_t     state_q;
    ipc_state_t     state_d;
    ipc_flash_req_t req_q;
    ipc_flash_req_t req_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic           busy_q;
    logic           busy_d;
    logic           done_q;
    logic           done_d;
    logic           invalid_q;
    logic           invalid_d;
    logic           got_q;
    logic           got_d;
    logic           clear;
    logic           take;
    logic           any_blank;
    logic           all_blank;

    // last byte of the image head reached
    function automatic logic head_end(input logic [CNT_W-1:0] n);
        return n == CNT_W'(CHECK_BYTES - 1);
    endfunction : head_end

    // next byte address, wrapping at the top of the flash space
    function automatic logic [23:0] step_addr(input logic [23:0] a);
        return a + 24'h000001;
    endfunction : step_addr

    // verdict over the bytes read
    ipc_byte_judge u_judge (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .clear_i     (clear),
        .take_i      (take),
        .byte_i      (flash_rsp_i.data),
        .any_blank_o (any_blank),
        .all_blank_o (all_blank)
    );

    // per-byte walk of the sequencer:
    //   idle    - a start latches the base address, raises the read enable
    //             and clears the byte judge, so an old verdict never leaks
    //   setup   - the address has stood on the port for at least a cycle;
    //             wait here until the flash side is no longer busy, since a
    //             read strobe into a busy controller would be lost
    //   launch  - the read strobe stands until the flash side shows busy;
    //             dropping it earlier could miss a slow controller, holding
    //             it longer would start a second read
    //   wait    - the address is frozen; the first valid byte is judged and
    //             later valid pulses of the same read are ignored
    //   drain   - step to the next byte or, after the last one, lower the
    //             read enable so the flash side may be handed to other users
    //   done    - publish the verdict, drop busy and pulse done together
    //
    // hazards and limits:
    //   a flash side that never raises busy after a read strobe stalls the
    //   walk in launch; the user logic owns any time limit on a check
    //   a flash side that never gives valid before dropping busy stalls the
    //   walk in wait for the same reason
    //   a start while busy is dropped silently; the user logic must wait for
    //   busy low before asking again
    //   the request group is registered, so the mux that shares the flash
    //   side with an updater sees clean levels from this block
    //
    // trade-off: one byte per read keeps the handshake trivial at the cost
    // of a few idle cycles per byte; a head of a few bytes is cheap anyway

    // sequencer next state
    always_comb begin
        state_d   = state_q;
        req_d     = req_q;
        cnt_d     = cnt_q;
        busy_d    = busy_q;
        done_d    = 1'b0;
        invalid_d = invalid_q;
        got_d     = got_q;
        clear     = 1'b0;
        take      = 1'b0;
        unique case (state_q)
            IPC_IDLE: begin
                if (start_i) begin
                    req_d.addr = start_addr_i;
                    req_d.rden = 1'b1;
                    cnt_d      = '0;
                    busy_d     = 1'b1;
                    invalid_d  = 1'b0;
                    clear      = 1'b1;
                    state_d    = IPC_SETUP;
                end
            end
            IPC_SETUP: begin
                // address already on the port for a cycle
                if (!flash_rsp_i.busy) begin
                    req_d.read = 1'b1;
                    got_d      = 1'b0;
                    state_d    = IPC_LAUNCH;
                end
            end
            IPC_LAUNCH: begin
                // hold read until the flash side takes it
                if (flash_rsp_i.busy) begin
                    req_d.read = 1'b0;
                    state_d    = IPC_WAIT;
                end
            end
            IPC_WAIT: begin
                // address frozen here
                if (flash_rsp_i.valid && !got_q) begin
                    take  = 1'b1;
                    got_d = 1'b1;
                end
                if (!flash_rsp_i.busy && (got_q || flash_rsp_i.valid)) begin
                    state_d = IPC_DRAIN;
                end
            end
            IPC_DRAIN: begin
                // one more byte, or release the flash side
                if (head_end(cnt_q)) begin
                    req_d.rden = 1'b0;
                    state_d    = IPC_DONE;
                end else begin
                    cnt_d      = cnt_q + CNT_W'(1);
                    req_d.addr = step_addr(req_q.addr);
                    state_d    = IPC_SETUP;
                end
            end
            IPC_DONE: begin
                // verdict, busy and done change on the same edge
                invalid_d = any_blank | all_blank;
                busy_d    = 1'b0;
                done_d    = 1'b1;
                state_d   = IPC_IDLE;
            end
            default: begin
                // unused state codes fall back to idle
                state_d = IPC_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q   <= IPC_IDLE;
            req_q     <= '{addr: START_ADDR_RST, read: 1'b0, rden: 1'b0};
            cnt_q     <= '0;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            invalid_q <= 1'b0;
            got_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            req_q     <= req_d;
            cnt_q     <= cnt_d;
            busy_q    <= busy_d;
            done_q    <= done_d;
            invalid_q <= invalid_d;
            got_q     <= got_d;
        end
    end


    // every output is a register: request group, busy, done and verdict
    assign flash_req_o = req_q;
    assign busy_o      = busy_q;
    assign done_o      = done_q;
    assign invalid_o   = invalid_q;
endmodule : ipc_checker
`default_nettype wire

// ==== verification/ipc_checker_sva.sv ====
// assertions on the image presence checker ports
`timescale 1ns/1ps
`default_nettype none
module ipc_checker_sva
    import ipc_pkg::*;
(
    input wire logic           ref_clk_i,
    input wire logic           srst_i,
    input wire logic           start_i,
    input wire logic [23:0]    start_addr_i,
    input wire ipc_flash_rsp_t flash_rsp_i,
    input wire ipc_flash_req_t flash_req_o,
    input wire logic           busy_o,
    input wire logic           done_o,
    input wire logic           invalid_o
);
    logic [23:0] base_q;
    logic        seen_q;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // mirror of the accepted start address and of any blank byte seen
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            base_q <= 24'h000000;
            seen_q <= 1'b0;
        end else if (start_i && !busy_o) begin
            base_q <= start_addr_i;
            seen_q <= 1'b0;
        end else if (busy_o && flash_rsp_i.valid && flash_rsp_i.data == BLANK_BYTE) begin
            seen_q <= 1'b1;
        end
    end
    property p_launch; $rose(flash_req_o.read) |-> !$past(flash_rsp_i.busy); endproperty
    a_launch: assert property (p_launch) else $error("read while flash busy");
    property p_setup; $rose(flash_req_o.read) |-> $stable(flash_req_o.addr); endproperty
    a_setup: assert property (p_setup) else $error("address not set up");
    property p_go; $rose(busy_o) |-> ##[1:3] flash_req_o.read; endproperty
    a_go: assert property (p_go) else $error("no read started");
    property p_rden; flash_req_o.read |-> flash_req_o.rden && busy_o; endproperty
    a_rden: assert property (p_rden) else $error("read without enable");
    property p_base; $rose(busy_o) |-> flash_req_o.addr == base_q; endproperty
    a_base: assert property (p_base) else $error("wrong first address");
    property p_range; flash_req_o.read |-> flash_req_o.addr - base_q < 24'h10; endproperty
    a_range: assert property (p_range) else $error("address out of head");
    property p_hold; flash_rsp_i.busy |-> $stable(flash_req_o.addr); endproperty
    a_hold: assert property (p_hold) else $error("address moved");
    property p_verdict; done_o |-> invalid_o == seen_q; endproperty
    a_verdict: assert property (p_verdict) else $error("wrong verdict");
    c_bad: cover property (done_o && invalid_o);
    c_good: cover property (done_o && !invalid_o);
    c_refuse: cover property (start_i && busy_o);
endmodule : ipc_checker_sva
bind ipc_checker ipc_checker_sva ipc_checker_sva_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .start_i(start_i), .start_addr_i(start_addr_i), .flash_rsp_i(flash_rsp_i),
    .flash_req_o(flash_req_o), .busy_o(busy_o), .done_o(done_o), .invalid_o(invalid_o));
`default_nettype wire

// ==== verification/ipc_flash_model.sv ====
// behavioural flash-access block answering byte reads
`timescale 1ns/1ps
`default_nettype none
module ipc_flash_model
    import ipc_pkg::*;
(
    input  wire logic           ref_clk_i,
    input  wire logic           srst_i,
    input  wire logic [23:0]    bad_addr_i,
    input  wire logic [2:0]     lat_i,
    input  wire ipc_flash_req_t req_i,
    output ipc_flash_rsp_t      rsp_o
);
    logic [2:0]     cnt_q;
    ipc_flash_rsp_t rsp_q;
    // busy spans the read, valid marks the one good byte; data toggles otherwise
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rsp_q <= '{busy: 1'b0, valid: 1'b0, data: 8'h00};
            cnt_q <= 3'h0;
        end else if (!rsp_q.busy && req_i.read && req_i.rden) begin
            rsp_q <= '{busy: 1'b1, valid: 1'b0, data: ~rsp_q.data};
            cnt_q <= lat_i;
        end else if (rsp_q.busy && cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
            if (cnt_q == 3'h1) begin
                rsp_q <= '{busy: 1'b1, valid: 1'b1,
                           data: (req_i.addr == bad_addr_i) ? 8'hFF
                                 : (req_i.addr[7:0] ^ 8'h5A)};
            end else begin
                rsp_q <= '{busy: 1'b1, valid: 1'b0, data: ~rsp_q.data};
            end
        end else begin
            rsp_q <= '{busy: 1'b0, valid: 1'b0, data: ~rsp_q.data};
        end
    end
    assign rsp_o = rsp_q;
endmodule : ipc_flash_model
`default_nettype wire

// ==== verification/ipc_checker_tb.sv ====
// self-checking bench for the image presence checker
`timescale 1ns/1ps
`default_nettype none
module ipc_checker_tb
    import ipc_pkg::*;
;
    logic           ref_clk_i = 1'b0;
    logic           srst_i = 1'b1;
    logic           start_i = 1'b0;
    logic [23:0]    start_addr_i = 24'h000000;
    logic [23:0]    bad_addr_i = 24'h000000;
    logic [2:0]     lat_i = 3'h1;
    ipc_flash_rsp_t rsp;
    ipc_flash_req_t req;
    logic           busy_o;
    logic           done_o;
    logic           invalid_o;
    int             bad_count = 0;
    int             checks_done = 0;
    // free-running clock
    always #4 ref_clk_i = ~ref_clk_i;
    ipc_checker ipc_checker_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .start_i(start_i),
        .start_addr_i(start_addr_i), .flash_rsp_i(rsp), .flash_req_o(req),
        .busy_o(busy_o), .done_o(done_o), .invalid_o(invalid_o));
    // sole user of the flash side: no mux, access held for the whole
    ipc_flash_model ipc_flash_model_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .bad_addr_i(bad_addr_i), .lat_i(lat_i), .req_i(req), .rsp_o(rsp));
    function automatic logic exp_invalid(input logic [23:0] a, input logic [23:0] bad);
        logic r;
        r = 1'b0;
        for (int k = 0; k < 16; k++) begin
            if (a + 24'(k) == bad || ((a[7:0] + 8'(k)) ^ 8'h5A) == 8'hFF) r = 1'b1;
        end
        return r;
    endfunction : exp_invalid
    task automatic chk(input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // one check, with a refused start in the middle of it
    task automatic run_check(input logic [23:0] a, input logic [23:0] bad);
        int n;
        @(posedge ref_clk_i);
        start_i      <= 1'b1;
        start_addr_i <= a;
        bad_addr_i   <= bad;
        lat_i        <= 3'($urandom_range(1, 4));
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        start_i      <= 1'b1;
        start_addr_i <= ~a;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        n = 0;
        @(negedge ref_clk_i);
        while (done_o !== 1'b1 && n < 2000) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n == 2000) begin
            bad_count++;
            end_of_test();
        end
        chk(exp_invalid(a, bad), invalid_o);
        chk(1'b0, busy_o);
        chk(1'b0, req.rden);
        $display("test addr=%h invalid=%h", a, invalid_o);
    endtask : run_check
    // corner cases first, then random heads
    initial begin
        logic [23:0] base;
        void'($urandom(3));
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        run_check(24'h000000, 24'h000000);
        run_check(24'h100000, 24'h10000F);
        run_check(24'h100000, 24'hFFFFFF);
        for (int i = 0; i < 10; i++) begin
            base = 24'($urandom);
            run_check(base, base + 24'($urandom_range(0, 31)));
        end
        // reset between checks clears the verdict, then a partly blank head
        @(posedge ref_clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(1'b0, invalid_o);
        run_check(24'h0000A0, 24'hFFFFFF);
        end_of_test();
    end
endmodule : ipc_checker_tb
`default_nettype wire
